// [shared/rti_consts.vh]
// constants for the resistance threshold and interrupt select register bank
`ifndef RTI_CONSTS_VH
`define RTI_CONSTS_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define RTI_ADDR_RES_HIGH_THR_LOW_BYTE 7'h06
`define RTI_ADDR_RES_HIGH_THR_HIGH_BYTE 7'h07
`define RTI_ADDR_RES_LOW_THR_LOW_BYTE 7'h08
`define RTI_ADDR_RES_LOW_THR_HIGH_BYTE 7'h09
`define RTI_ADDR_IRQ_SELECT 7'h0A
`define RTI_ADDR_OPERATING_STATE 7'h0B

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RTI_RST_THR_BYTE 8'h00
`define RTI_RST_IRQ_SELECT 8'h00
`define RTI_RST_OPERATING_STATE 8'h01
`define RTI_RST_THRESHOLD 16'h0000
`define RTI_RST_FUNC_MODE 2'h1

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define RTI_IRQ_ROUTE_BIT 7
`define RTI_IRQ_EVENT_MSB 5
`define RTI_IRQ_EVENT_LSB 0
`define RTI_FUNC_MODE_MSB 1
`define RTI_FUNC_MODE_LSB 0
`define RTI_FUNC_MODE_ACTIVE 2'h0

// ----------------------------------------------------------------
// interrupt event select codes
// ----------------------------------------------------------------
`define RTI_EVT_NONE 6'h00
`define RTI_EVT_RES_LATCH 6'h01
`define RTI_EVT_RES_HYST 6'h02
`define RTI_EVT_RES_IND_READY 6'h04
`define RTI_EVT_IND_LATCH 6'h08
`define RTI_EVT_IND_HYST 6'h10
`define RTI_EVT_HIGH_RES_READY 6'h20

// ----------------------------------------------------------------
// serial frame layout
// ----------------------------------------------------------------
`define RTI_FRAME_BITS 5'h10
`define RTI_CMD_BITS 5'h08
`define RTI_READ_DATA_ZERO 8'h00

`endif

// [rtl/rti_pin_sync.v]
// three-stage synchroniser with agreement filter for asynchronous pins
module rti_pin_sync #(
    parameter WIDTH = 3,
    parameter [WIDTH-1:0] RESET_VALUE = {WIDTH{1'b0}}
) (
    input wire clk_sys_in,              // system clock
    input wire rst_b_in,                // asynchronous reset, active low
    input wire [WIDTH-1:0] async_in,    // raw pin levels
    output reg [WIDTH-1:0] level_out,   // filtered level
    output reg [WIDTH-1:0] rise_out,    // one-cycle pulse on a filtered rise
    output reg [WIDTH-1:0] fall_out     // one-cycle pulse on a filtered fall
);

reg [WIDTH-1:0] stage1;
reg [WIDTH-1:0] stage2;
reg [WIDTH-1:0] stage3;
wire [WIDTH-1:0] agree;
wire [WIDTH-1:0] next_level;

// ----------------------------------------------------------------
// stage 1 is read only by stage 2; the filter looks at 2 and 3
// ----------------------------------------------------------------
assign agree = ~(stage2 ^ stage3);
assign next_level = (agree & stage3) | (~agree & level_out);

always @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
        stage1 <= RESET_VALUE;
        stage2 <= RESET_VALUE;
        stage3 <= RESET_VALUE;
        level_out <= RESET_VALUE;
        rise_out <= {WIDTH{1'b0}};
        fall_out <= {WIDTH{1'b0}};
    end else begin
        stage1 <= async_in;
        stage2 <= stage1;
        stage3 <= stage2;
        level_out <= next_level;
        rise_out <= next_level & ~level_out;
        fall_out <= ~next_level & level_out;
    end
end

endmodule

// [rtl/rti_res_thr_irq.v]
// resistance threshold compare, interrupt select and serial register port
//
// Functional notes
// - high threshold is high byte*256 plus low
// - low threshold is high byte*256 plus low
// - high flag when result exceeds high threshold
// - low flag when result below low threshold
// - high-threshold low byte buffered until high write
// - low-threshold low byte buffered until high write
// - writes accepted while converting in active mode
// - route bit drives interrupt onto data-out pin
// - selected event reaches pin only when routed
// - codes pick data-ready events
// - codes pick hysteresis or latching comparisons
// - code zero means no output; others reserved
`include "rti_consts.vh"

module rti_res_thr_irq (
    input wire clk_sys_in,                  // system clock, 40 MHz
    input wire rst_b_in,                    // asynchronous reset, active low
    input wire spi_sclk_in,                 // serial clock from host
    input wire spi_cs_b_in,                 // serial chip select, active low
    input wire spi_sdi_in,                  // serial data in
    output reg spi_sdo_out,                 // serial data-out pin level
    output reg spi_sdo_oe_out,              // data-out pin output enable
    input wire [15:0] res_conversion_result_in, // resistance conversion result
    input wire res_result_valid_in,         // pulse: new resistance result
    input wire res_ind_ready_in,            // pulse: combined resistance plus inductance ready
    input wire high_res_ready_in,           // pulse: high-resolution inductance ready
    input wire ind_above_high_in,           // inductance compare above its high threshold
    input wire ind_below_low_in,            // inductance compare below its low threshold
    output reg res_above_high_flag_out,     // result above committed high threshold
    output reg res_below_low_flag_out,      // result below committed low threshold
    output reg [15:0] res_high_threshold_out, // committed high threshold
    output reg [15:0] res_low_threshold_out,  // committed low threshold
    output reg [1:0] func_mode_out,         // functional mode field
    output reg interrupt_out_n_out          // selected interrupt, active low
);

// ----------------------------------------------------------------
// pin synchronisation
// ----------------------------------------------------------------
wire [2:0] pin_level;
wire [2:0] pin_rise;
wire [2:0] pin_fall;
wire sdi_level;
wire sclk_rise;
wire cs_fall;
wire cs_active;

rti_pin_sync #(
    .WIDTH(3),
    .RESET_VALUE(3'h2)
) u_pin_sync (
    .clk_sys_in(clk_sys_in),
    .rst_b_in(rst_b_in),
    .async_in({spi_sdi_in, spi_cs_b_in, spi_sclk_in}),
    .level_out(pin_level),
    .rise_out(pin_rise),
    .fall_out(pin_fall)
);

assign sclk_rise = pin_rise[0];
assign cs_fall = pin_fall[1];
assign cs_active = ~pin_level[1];
assign sdi_level = pin_level[2];

// ----------------------------------------------------------------
// register state
// ----------------------------------------------------------------
reg [7:0] high_thr_low_shadow;
reg [7:0] high_thr_high_byte;
reg [7:0] low_thr_low_shadow;
reg [7:0] low_thr_high_byte;
reg [7:0] irq_select_reg;
reg [7:0] operating_state;

// ----------------------------------------------------------------
// serial frame engine
// ----------------------------------------------------------------
reg [4:0] bit_count;
reg [7:0] rx_shift;
reg [7:0] tx_shift;
reg frame_read;
reg [6:0] frame_addr;
reg [7:0] read_data;
wire [7:0] rx_next;
wire cmd_done;
wire frame_done;
wire write_strobe;
wire [7:0] write_data;

assign rx_next = {rx_shift[6:0], sdi_level};
assign cmd_done = cs_active && sclk_rise && (bit_count == `RTI_CMD_BITS - 5'h01);
assign frame_done = cs_active && sclk_rise && (bit_count == `RTI_FRAME_BITS - 5'h01);
assign write_strobe = frame_done && !frame_read;
assign write_data = rx_next;

always @* begin
    case (rx_next[6:0])
        `RTI_ADDR_RES_HIGH_THR_LOW_BYTE: read_data = high_thr_low_shadow;
        `RTI_ADDR_RES_HIGH_THR_HIGH_BYTE: read_data = high_thr_high_byte;
        `RTI_ADDR_RES_LOW_THR_LOW_BYTE: read_data = low_thr_low_shadow;
        `RTI_ADDR_RES_LOW_THR_HIGH_BYTE: read_data = low_thr_high_byte;
        `RTI_ADDR_IRQ_SELECT: read_data = irq_select_reg;
        `RTI_ADDR_OPERATING_STATE: read_data = operating_state;
        default: read_data = `RTI_READ_DATA_ZERO;
    endcase
end

// data is shifted out on the detected rising edge so it has a full sclk
// period to settle before the host samples it on the next rise
always @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
        bit_count <= 5'h00;
        rx_shift <= 8'h00;
        tx_shift <= 8'h00;
        frame_read <= 1'b0;
        frame_addr <= 7'h00;
    end else begin
        if (cs_fall || !cs_active) begin
            bit_count <= 5'h00;
            rx_shift <= 8'h00;
            tx_shift <= 8'h00;
        end else if (sclk_rise) begin
            rx_shift <= rx_next;
            if (bit_count != `RTI_FRAME_BITS) begin
                bit_count <= bit_count + 5'h01;
            end
            if (cmd_done) begin
                frame_read <= rx_next[7];
                frame_addr <= rx_next[6:0];
                tx_shift <= read_data;
            end else begin
                tx_shift <= {tx_shift[6:0], 1'b0};
            end
        end
    end
end

// ----------------------------------------------------------------
// register writes, accepted in every functional mode
// ----------------------------------------------------------------
wire sel_write;

assign sel_write = write_strobe && (frame_addr == `RTI_ADDR_IRQ_SELECT);

always @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
        high_thr_low_shadow <= `RTI_RST_THR_BYTE;
        high_thr_high_byte <= `RTI_RST_THR_BYTE;
        low_thr_low_shadow <= `RTI_RST_THR_BYTE;
        low_thr_high_byte <= `RTI_RST_THR_BYTE;
        irq_select_reg <= `RTI_RST_IRQ_SELECT;
        operating_state <= `RTI_RST_OPERATING_STATE;
        res_high_threshold_out <= `RTI_RST_THRESHOLD;
        res_low_threshold_out <= `RTI_RST_THRESHOLD;
    end else if (write_strobe) begin
        case (frame_addr)
            `RTI_ADDR_RES_HIGH_THR_LOW_BYTE: begin
                high_thr_low_shadow <= write_data;
            end
            `RTI_ADDR_RES_HIGH_THR_HIGH_BYTE: begin
                high_thr_high_byte <= write_data;
                res_high_threshold_out <= {write_data, high_thr_low_shadow};
            end
            `RTI_ADDR_RES_LOW_THR_LOW_BYTE: begin
                low_thr_low_shadow <= write_data;
            end
            `RTI_ADDR_RES_LOW_THR_HIGH_BYTE: begin
                low_thr_high_byte <= write_data;
                res_low_threshold_out <= {write_data, low_thr_low_shadow};
            end
            `RTI_ADDR_IRQ_SELECT: begin
                irq_select_reg <= write_data;
            end
            `RTI_ADDR_OPERATING_STATE: begin
                operating_state <= write_data;
            end
            default: begin
                operating_state <= operating_state;
            end
        endcase
    end
end

always @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
        func_mode_out <= `RTI_RST_FUNC_MODE;
    end else begin
        func_mode_out <= operating_state[`RTI_FUNC_MODE_MSB:`RTI_FUNC_MODE_LSB];
    end
end

// ----------------------------------------------------------------
// resistance comparison
// ----------------------------------------------------------------
wire res_above;
wire res_below;

assign res_above = res_conversion_result_in > res_high_threshold_out;
assign res_below = res_conversion_result_in < res_low_threshold_out;

always @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
        res_above_high_flag_out <= 1'b0;
        res_below_low_flag_out <= 1'b0;
    end else if (res_result_valid_in) begin
        res_above_high_flag_out <= res_above;
        res_below_low_flag_out <= res_below;
    end
end

// ----------------------------------------------------------------
// event state behind the interrupt selector
// ----------------------------------------------------------------
reg res_hyst;
reg res_latch;
reg ind_hyst;
reg ind_latch;
reg res_ind_ready_hold;
reg high_res_ready_hold;

// hysteresis: set above high, released only below low
always @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
        res_hyst <= 1'b0;
        ind_hyst <= 1'b0;
    end else begin
        if (res_result_valid_in && res_above) begin
            res_hyst <= 1'b1;
        end else if (res_result_valid_in && res_below) begin
            res_hyst <= 1'b0;
        end
        if (ind_above_high_in) begin
            ind_hyst <= 1'b1;
        end else if (ind_below_low_in) begin
            ind_hyst <= 1'b0;
        end
    end
end

// latches hold until the selector is rewritten; a new event wins over that clear
always @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
        res_latch <= 1'b0;
        ind_latch <= 1'b0;
    end else begin
        if (res_result_valid_in && res_above) begin
            res_latch <= 1'b1;
        end else if (sel_write) begin
            res_latch <= 1'b0;
        end
        if (ind_above_high_in) begin
            ind_latch <= 1'b1;
        end else if (sel_write) begin
            ind_latch <= 1'b0;
        end
    end
end

// data-ready holds until the host opens its next frame; a new ready wins
always @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
        res_ind_ready_hold <= 1'b0;
        high_res_ready_hold <= 1'b0;
    end else begin
        if (res_ind_ready_in) begin
            res_ind_ready_hold <= 1'b1;
        end else if (cs_fall) begin
            res_ind_ready_hold <= 1'b0;
        end
        if (high_res_ready_in) begin
            high_res_ready_hold <= 1'b1;
        end else if (cs_fall) begin
            high_res_ready_hold <= 1'b0;
        end
    end
end

// ----------------------------------------------------------------
// interrupt selection
// ----------------------------------------------------------------
reg irq_selected;
wire [5:0] irq_event_select;
wire irq_route_to_dout;

assign irq_event_select = irq_select_reg[`RTI_IRQ_EVENT_MSB:`RTI_IRQ_EVENT_LSB];
assign irq_route_to_dout = irq_select_reg[`RTI_IRQ_ROUTE_BIT];

// reserved codes behave as code zero: no interrupt
always @* begin
    case (irq_event_select)
        `RTI_EVT_HIGH_RES_READY: irq_selected = high_res_ready_hold;
        `RTI_EVT_RES_IND_READY: irq_selected = res_ind_ready_hold;
        `RTI_EVT_IND_HYST: irq_selected = ind_hyst;
        `RTI_EVT_IND_LATCH: irq_selected = ind_latch;
        `RTI_EVT_RES_HYST: irq_selected = res_hyst;
        `RTI_EVT_RES_LATCH: irq_selected = res_latch;
        `RTI_EVT_NONE: irq_selected = 1'b0;
        default: irq_selected = 1'b0;
    endcase
end

// ----------------------------------------------------------------
// output pins
// ----------------------------------------------------------------
// outside a frame the pin shows the interrupt only when routed;
// during a read frame it carries read data after the command byte
always @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
        interrupt_out_n_out <= 1'b1;
        spi_sdo_out <= 1'b0;
        spi_sdo_oe_out <= 1'b0;
    end else begin
        interrupt_out_n_out <= ~irq_selected;
        if (cs_active) begin
            spi_sdo_out <= tx_shift[7];
            spi_sdo_oe_out <= frame_read && (bit_count >= `RTI_CMD_BITS);
        end else begin
            spi_sdo_out <= ~irq_selected;
            spi_sdo_oe_out <= irq_route_to_dout;
        end
    end
end

endmodule

// [sim/rti_monitor.sv]
// concurrent checks on the ports of the resistance threshold block
module rti_monitor (
    input wire logic clk_sys_in, // system clock
    input wire logic rst_b_in, // reset, active low
    input wire logic spi_cs_b_in, // chip select, active low
    input wire logic spi_sdo_out, // data-out pin level
    input wire logic spi_sdo_oe_out, // data-out enable
    input wire logic [15:0] res_conversion_result_in, // result
    input wire logic res_result_valid_in, // result strobe
    input wire logic res_above_high_flag_out, // high flag
    input wire logic res_below_low_flag_out, // low flag
    input wire logic [15:0] res_high_threshold_out, // high threshold
    input wire logic [15:0] res_low_threshold_out, // low threshold
    input wire logic [1:0] func_mode_out, // mode field
    input wire logic interrupt_out_n_out // interrupt, active low
);
    timeunit 1ns;
    timeprecision 100ps;
    // ----------------------------------------
    // sequences and properties
    // ----------------------------------------
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!rst_b_in);
    // eight quiet cycles: any commit from the last frame has landed by then
    sequence s_idle;
        spi_cs_b_in [*8];
    endsequence
    sequence s_new_result;
        res_result_valid_in ##1 1'b1;
    endsequence
    a_high_flag: assert property (s_new_result |->
        res_above_high_flag_out == ($past(res_conversion_result_in) > $past(res_high_threshold_out)))
        else $error("high flag disagrees with result");
    a_low_flag: assert property (s_new_result |->
        res_below_low_flag_out == ($past(res_conversion_result_in) < $past(res_low_threshold_out)))
        else $error("low flag disagrees with result");
    a_flag_hold: assert property (!res_result_valid_in |=>
        $stable(res_above_high_flag_out) && $stable(res_below_low_flag_out))
        else $error("flag moved without a result");
    a_high_thr_quiet: assert property (s_idle |-> $stable(res_high_threshold_out))
        else $error("high threshold moved outside a frame");
    a_low_thr_quiet: assert property (s_idle |-> $stable(res_low_threshold_out))
        else $error("low threshold moved outside a frame");
    a_mode_quiet: assert property (s_idle |-> $stable(func_mode_out))
        else $error("mode moved outside a frame");
    a_oe_quiet: assert property (s_idle |-> $stable(spi_sdo_oe_out))
        else $error("pin enable moved outside a frame");
    a_sdo_carries_irq: assert property (s_idle ##0 spi_sdo_oe_out |->
        spi_sdo_out == interrupt_out_n_out || spi_sdo_out == $past(interrupt_out_n_out))
        else $error("data-out pin does not carry the interrupt");
endmodule

bind rti_res_thr_irq rti_monitor rti_monitor_i (.clk_sys_in, .rst_b_in, .spi_cs_b_in, .spi_sdo_out,
    .spi_sdo_oe_out, .res_conversion_result_in, .res_result_valid_in, .res_above_high_flag_out,
    .res_below_low_flag_out, .res_high_threshold_out, .res_low_threshold_out, .func_mode_out,
    .interrupt_out_n_out);

// [sim/rti_host_model.sv]
// host side serial master that issues 16-bit register frames
module rti_host_model (
    output logic sclk_out, // serial clock, idle low
    output logic cs_b_out, // chip select, active low
    output logic sdi_out, // data to the device
    input wire logic sdo_in, // data-out pin level
    input wire logic sdo_oe_in // device drives data-out
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        sclk_out = 1'b0;
        cs_b_out = 1'b1;
        sdi_out = 1'b0;
    end
    // mode 0, 200 ns bit time; an undriven pin reads as the inverse of its last level
    task automatic xfer(input logic [15:0] frame, output logic [7:0] rd);
        logic pin;
        pin = 1'b0;
        rd = 8'h00;
        cs_b_out = 1'b0;
        #100;
        for (int i = 15; i >= 0; i--) begin
            sdi_out = frame[i];
            #100;
            pin = sdo_oe_in ? sdo_in : ~pin;
            if (i < 8) rd[i] = pin;
            sclk_out = 1'b1;
            #100;
            sclk_out = 1'b0;
        end
        #100;
        cs_b_out = 1'b1;
        // stale data never looks like a held bit
        sdi_out = ~sdi_out;
        #150;
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] rd;
        xfer({1'b0, a, d}, rd);
    endtask
    task automatic wr_thr(input logic [6:0] a, input logic [15:0] v);
        wr(a, v[7:0]);
        wr(a + 7'h01, v[15:8]);
    endtask
endmodule

// [sim/testbench.sv]
// self-checking bench for the resistance threshold and interrupt select block
`include "rti_consts.vh"
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_sys_in, rst_b_in, sclk, cs_b, sdi, sdo, sdo_oe, valid, ri_rdy, hr_rdy, ind_hi, ind_lo;
    logic flag_hi, flag_lo, irq_n;
    logic [15:0] result, thr_hi, thr_lo;
    logic [1:0] fmode;
    logic [7:0] rd;
    int miscompares = 0;
    int checks = 0;
    rti_res_thr_irq rti_res_thr_irq_i (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .spi_sclk_in(sclk),
        .spi_cs_b_in(cs_b), .spi_sdi_in(sdi), .spi_sdo_out(sdo), .spi_sdo_oe_out(sdo_oe),
        .res_conversion_result_in(result), .res_result_valid_in(valid), .res_ind_ready_in(ri_rdy),
        .high_res_ready_in(hr_rdy), .ind_above_high_in(ind_hi), .ind_below_low_in(ind_lo),
        .res_above_high_flag_out(flag_hi), .res_below_low_flag_out(flag_lo), .res_high_threshold_out(thr_hi),
        .res_low_threshold_out(thr_lo), .func_mode_out(fmode), .interrupt_out_n_out(irq_n));
    rti_host_model rti_host_model_i (.sclk_out(sclk), .cs_b_out(cs_b), .sdi_out(sdi), .sdo_in(sdo),
        .sdo_oe_in(sdo_oe));
    initial begin
        clk_sys_in = 1'b0;
        forever #12.5 clk_sys_in = ~clk_sys_in;
    end
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge clk_sys_in);
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        rti_host_model_i.wr(a, d);
        idle(8);
    endtask
    task automatic rdreg(input logic [6:0] a);
        rti_host_model_i.xfer({1'b1, a, 8'h00}, rd);
    endtask
    task automatic fire(input logic [4:0] ev, input logic [15:0] r);
        @(negedge clk_sys_in);
        {valid, ri_rdy, hr_rdy, ind_hi, ind_lo} = ev;
        result = r;
        @(negedge clk_sys_in);
        {valid, ri_rdy, hr_rdy, ind_hi, ind_lo} = 5'h00;
        idle(4);
    endtask
    task automatic pin(input logic [2:0] exp);
        chk(16'({irq_n, sdo_oe, sdo}), 16'(exp));
    endtask
    task automatic stop_test;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset;
        chk(16'({irq_n, sdo_oe, fmode}), 16'h0009);
        chk(thr_hi | thr_lo, 16'h0000);
        for (int a = 6; a <= 12; a++) begin
            rdreg(7'(a == 12 ? 127 : a));
            chk(16'(rd), a == 11 ? 16'h0001 : 16'h0000);
        end
        $display("test reset done");
    endtask
    task automatic t_mode;
        wr(`RTI_ADDR_OPERATING_STATE, 8'h00);
        wr(7'h7F, 8'hFF);
        rdreg(7'h7F);
        chk(16'({fmode, rd}), 16'h0000);
        $display("test mode done");
    endtask
    task automatic t_thr;
        wr(`RTI_ADDR_RES_HIGH_THR_LOW_BYTE, 8'h34);
        chk(thr_hi, 16'h0000);
        rdreg(`RTI_ADDR_RES_HIGH_THR_LOW_BYTE);
        chk(16'(rd), 16'h0034);
        wr(`RTI_ADDR_RES_HIGH_THR_HIGH_BYTE, 8'h12);
        chk(thr_hi, 16'h1234);
        rti_host_model_i.wr_thr(`RTI_ADDR_RES_LOW_THR_LOW_BYTE, 16'h0156);
        idle(8);
        chk(thr_lo, 16'h0156);
        wr(`RTI_ADDR_RES_LOW_THR_LOW_BYTE, 8'hFF);
        chk(thr_lo, 16'h0156);
        $display("test threshold done");
    endtask
    task automatic t_cmp;
        logic [17:0] tab [6] = '{{16'h1234, 2'b00}, {16'h1235, 2'b10}, {16'h0156, 2'b00},
            {16'h0155, 2'b01}, {16'hFFFF, 2'b10}, {16'h0000, 2'b01}};
        for (int i = 0; i < 6; i++) begin
            fire(5'h10, tab[i][17:2]);
            chk(16'({flag_hi, flag_lo}), 16'(tab[i][1:0]));
        end
        $display("test compare done");
    endtask
    task automatic t_irq;
        logic [10:0] tab [6] = '{{`RTI_EVT_RES_LATCH, 5'h10}, {`RTI_EVT_RES_HYST, 5'h10},
            {`RTI_EVT_RES_IND_READY, 5'h08}, {`RTI_EVT_IND_LATCH, 5'h02}, {`RTI_EVT_IND_HYST, 5'h02},
            {`RTI_EVT_HIGH_RES_READY, 5'h04}};
        for (int i = 0; i < 6; i++) begin
            wr(`RTI_ADDR_IRQ_SELECT, {2'b10, tab[i][10:5]});
            fire(tab[i][4:0], 16'h2000);
            pin(3'b010);
        end
        // inductance hysteresis releases only on its below-low input
        wr(`RTI_ADDR_IRQ_SELECT, 8'h90);
        fire(5'h01, 16'h2000);
        pin(3'b111);
        fire(5'h02, 16'h2000);
        pin(3'b010);
        // hysteresis holds between the thresholds and clears only below low
        wr(`RTI_ADDR_IRQ_SELECT, 8'h82);
        fire(5'h10, 16'h1000);
        pin(3'b010);
        fire(5'h10, 16'h0100);
        pin(3'b111);
        fire(5'h10, 16'h1000);
        pin(3'b111);
        wr(`RTI_ADDR_IRQ_SELECT, 8'h81);
        fire(5'h10, 16'h2000);
        fire(5'h10, 16'h0100);
        pin(3'b010);
        // a pending event without the route bit leaves the data-out pin undriven
        wr(`RTI_ADDR_IRQ_SELECT, 8'h01);
        fire(5'h10, 16'h2000);
        pin(3'b000);
        wr(`RTI_ADDR_IRQ_SELECT, 8'h80);
        fire(5'h1F, 16'h2000);
        pin(3'b111);
        wr(`RTI_ADDR_IRQ_SELECT, 8'h83);
        fire(5'h1F, 16'h2000);
        pin(3'b111);
        $display("test interrupt done");
    endtask
    initial begin
        rst_b_in = 1'b0;
        {valid, ri_rdy, hr_rdy, ind_hi, ind_lo} = 5'h00;
        result = 16'h0000;
        repeat (8) @(posedge clk_sys_in);
        @(negedge clk_sys_in);
        rst_b_in = 1'b1;
        idle(4);
        t_reset();
        t_mode();
        t_thr();
        t_cmp();
        t_irq();
        stop_test();
    end
    // the whole run needs roughly 107 us
    initial begin
        #1000000;
        miscompares++;
        stop_test();
    end
endmodule
